// ==== serial_byte_master_pkg.sv ====
// Constants shared by the serial byte master port: register offsets, field positions,
// reset values, command enable bit positions and serial clock timing.
// Assumes a byte-wide register port decoding a 12-bit offset.
package serial_byte_master_pkg;

    // Register offsets.
    localparam logic [11:0] OFS_CONTROL  = 12'h0cd0;
    localparam logic [11:0] OFS_TRANSMIT = 12'h0cd1;
    localparam logic [11:0] OFS_COMMAND  = 12'h0cd2;
    localparam logic [11:0] OFS_STATUS   = 12'h0cd3;
    localparam logic [11:0] OFS_RECEIVE  = 12'h0cd4;

    // Control register field positions.
    localparam int CTL_DONE_IRQ_ENABLE  = 0;
    localparam int CTL_PHASE_INVERT     = 1;
    localparam int CTL_CLOCK_IDLE_LOW   = 2;
    localparam int CTL_MSB_FIRST        = 3;
    localparam int CTL_RATE_LSB         = 4;
    localparam int RATE_W               = 3;

    // Status register field positions.
    localparam int STA_BUSY             = 0;
    localparam int STA_DONE             = 1;

    // Command register field positions: transmit and receive enables.
    localparam int CMD_TRANSMIT         = 0;
    localparam int CMD_RECEIVE          = 1;

    // Reset values.
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic       SCLK_RESET   = 1'b1;

    // Serial clock timing: fastest serial rate and system rate in kHz.
    localparam int SYS_CLK_KHZ          = 200000;
    localparam int SCLK_FAST_KHZ        = 8000;
    localparam int HALF_BASE_CYCLES     = SYS_CLK_KHZ / (2 * SCLK_FAST_KHZ);

    // Edge numbering within one byte.
    localparam logic [4:0] EDGE_LAST    = 5'h10;
    localparam logic [4:0] EDGE_LAST_TX_INV = 5'h0e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } xfer_state_t;

endpackage

// ==== serial_half_period_timer.sv ====
// Half-period tick generator for the serial clock.
// Assumes i_run is held high for the whole byte and dropped between bytes.
`timescale 1ns/1ps
`default_nettype none

module serial_half_period_timer #(
    parameter int DIV_W = 11
) (
    input  wire logic                                  i_clk_sys, // System clock.
    input  wire logic                                  i_rst,     // Synchronous reset.
    input  wire logic                                  i_ce,      // Clock enable.
    input  wire logic                                  i_run,     // Count while high.
    input  wire logic [serial_byte_master_pkg::RATE_W-1:0] i_sel, // Rate select.
    output logic                                       o_tick     // Half-period pulse.
);
    import serial_byte_master_pkg::*;

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] half_len;

    // The slowest rate must fit in the counter.
    if ((HALF_BASE_CYCLES << ((1 << RATE_W) - 1)) >= (1 << DIV_W)) begin : g_chk
        $error("serial_half_period_timer: DIV_W too small");
    end

    // [RL6] divide system clock
    assign half_len = DIV_W'(HALF_BASE_CYCLES) << i_sel;
    assign o_tick   = i_run && (cnt_q == half_len - DIV_W'(1));

    // Counter restarts from zero whenever the byte is not running.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else if (i_ce) begin
            if (!i_run || o_tick) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + DIV_W'(1);
            end
        end
    end

endmodule

`default_nettype wire

// ==== serial_byte_master_port.sv ====
// Master-only serial port shifting one byte per command, with five byte registers.
// Assumes inputs synchronous to i_clk_sys; peripheral enables are driven elsewhere.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RL1] All three selects at 1 give inverted phase, low idle, high bit first.
// [RL2] Selects 0,0 with high bit first give high idle, normal phase framing.
// [RL3] Software emulates nibble reads with full-duplex and ignoring four bits.
// [RL4] Normal phase completes half a serial period after the last sample edge.
// [RL5] One byte per command, at least one idle system cycle between bytes.
// [RL6] Serial clock is the system clock divided by the rate select field.
// [RL7] Interrupt request only while done interrupt enable is 1.
// [RL8] Completion clears busy, sets done, raises enabled interrupt.
// [RL9] Status updates half period after last receive or full after last transmit.
// [RL10] Writing 1 clears done flag; writing 0 leaves it.
// [RL11] Busy sets as soon as the command register is written.
// [RL12] Software avoids writing transmit, control, command while busy.
// [RL13] Software loads the transmit byte before the command.
// [RL14] Software reads the receive byte only after completion.
// [RL15] Reset clears every register; port idles without clock until a command.
// [RL16] Peripheral enables come from software general pins, not this port.
// [RL17] Clock idles high when idle-low select is 0, low when 1.
// [RL18] Normal phase drives odd, samples even; inverted samples odd, drives early.
// [RL19] High bit first select orders both directions; otherwise low bit first.
// [RL20] Always master, eight serial clock cycles, transmit, receive or both; a command with both enables at 0 also runs a clocks-only byte.
// [RL21] Data out released when not transmitting; receive byte ready when busy clears.
module serial_byte_master_port #(
    parameter int DIV_W = 11
) (
    input  wire logic        i_clk_sys,  // System clock, 200 MHz.
    input  wire logic        i_rst,      // Synchronous reset, active high.
    input  wire logic        i_ce,       // Clock enable, freezes all state when low.
    input  wire logic [11:0] i_addr,     // Register offset.
    input  wire logic        i_wr,       // Write strobe.
    input  wire logic        i_rd,       // Read strobe.
    input  wire logic [7:0]  i_wdata,    // Write data.
    output logic      [7:0]  o_rdata,    // Read data, registered.
    output logic             o_irq,      // Done interrupt request.
    output logic             o_sclk,     // Serial clock out.
    output logic             o_sdo,      // Serial data out.
    output logic             o_sdo_oe,   // Serial data out enable.
    input  wire logic        i_sdi       // Serial data in.
);
    import serial_byte_master_pkg::*;

    xfer_state_t state_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  txreg_q;
    logic [7:0]  cmd_q;
    logic [7:0]  rxreg_q;
    logic        busy_q;
    logic        done_q;
    logic [7:0]  txsh_q;
    logic [7:0]  rxsh_q;
    logic [4:0]  edge_q;
    logic        sclk_q;
    logic        sdo_q;
    logic        tick;
    logic [4:0]  edge_n;
    logic        inv_phase;
    logic        msb_first;
    logic        idle_level;
    logic        cmd_wr;
    logic        drive_ev;
    logic        sample_ev;
    logic        finish;
    logic        next_bit;

    //////////////////////////////////////////////////////////////////////////////////////
    // Decode.

    // [RL1] [RL2] framing select bits
    assign inv_phase  = ctrl_q[CTL_PHASE_INVERT];
    assign msb_first  = ctrl_q[CTL_MSB_FIRST];
    // [RL17] idle level select
    assign idle_level = ~ctrl_q[CTL_CLOCK_IDLE_LOW];
    // Commands written while busy are dropped so a command write never corrupts a running byte.
    assign cmd_wr     = i_wr && (i_addr == OFS_COMMAND) && !busy_q;
    assign edge_n     = edge_q + 5'h01;

    // [RL18] drive and sample edges
    always_comb begin
        drive_ev  = 1'b0;
        sample_ev = 1'b0;
        if (tick && state_q == ST_SHIFT && edge_q < EDGE_LAST) begin
            if (inv_phase) begin
                drive_ev  = !edge_n[0] && (edge_n <= EDGE_LAST_TX_INV);
                sample_ev = edge_n[0];
            end else begin
                drive_ev  = edge_n[0];
                sample_ev = !edge_n[0];
            end
        end
    end

    // [RL4] half period after last sample
    // [RL9] status update instant
    assign finish = tick && state_q == ST_SHIFT &&
                    (inv_phase ? (edge_n == EDGE_LAST) : (edge_q == EDGE_LAST));

    // [RL19] bit order selection
    assign next_bit = msb_first ? txsh_q[7] : txsh_q[0];

    //////////////////////////////////////////////////////////////////////////////////////
    // Timer.

    serial_half_period_timer #(
        .DIV_W (DIV_W)
    ) u_timer (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_run     (state_q == ST_SHIFT),
        .i_sel     (ctrl_q[CTL_RATE_LSB +: RATE_W]),
        .o_tick    (tick)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // Registers written by software.

    // [RL15] registers clear on reset
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl_q  <= REG_RESET;
            txreg_q <= REG_RESET;
            cmd_q   <= REG_RESET;
        end else if (i_ce && i_wr) begin
            if (i_addr == OFS_CONTROL) begin
                ctrl_q <= i_wdata;
            end
            if (i_addr == OFS_TRANSMIT) begin
                txreg_q <= i_wdata;
            end
            if (cmd_wr) begin
                cmd_q <= i_wdata;
            end
        end
    end

    // [RL11] busy on command write
    // [RL8] busy clears on completion
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            busy_q <= 1'b0;
        end else if (i_ce) begin
            if (cmd_wr) begin
                busy_q <= 1'b1;
            end else if (finish) begin
                busy_q <= 1'b0;
            end
        end
    end

    // [RL10] write one clears done
    // A completion in the same cycle as the clear keeps the flag set.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            done_q <= 1'b0;
        end else if (i_ce) begin
            if (finish) begin
                done_q <= 1'b1;
            end else if (i_wr && i_addr == OFS_STATUS && i_wdata[STA_DONE]) begin
                done_q <= 1'b0;
            end
        end
    end

    // [RL7] gated interrupt request
    assign o_irq = done_q && ctrl_q[CTL_DONE_IRQ_ENABLE];

    // Registered read data; unmapped offsets read as zero.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= REG_RESET;
        end else if (i_ce && i_rd) begin
            unique case (i_addr)
                OFS_CONTROL:  o_rdata <= ctrl_q;
                OFS_TRANSMIT: o_rdata <= txreg_q;
                OFS_COMMAND:  o_rdata <= cmd_q;
                OFS_STATUS:   o_rdata <= {6'h00, done_q, busy_q};
                OFS_RECEIVE:  o_rdata <= rxreg_q;
                default:      o_rdata <= 8'h00;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Byte sequencer.

    // [RL20] eight clock cycles per command
    // [RL5] one byte per command
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            edge_q  <= 5'h00;
        end else if (i_ce) begin
            unique case (state_q)
                ST_IDLE: begin
                    edge_q <= 5'h00;
                    if (cmd_wr) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (finish) begin
                        state_q <= ST_IDLE;
                    end else if (tick) begin
                        edge_q <= edge_n;
                    end
                end
            endcase
        end
    end

    // Serial clock toggles on edges 1 to 16 and so ends each byte at its idle level.
    // [RL17] clock idle and pulse
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sclk_q <= SCLK_RESET;
        end else if (i_ce) begin
            if (state_q != ST_SHIFT) begin
                sclk_q <= idle_level;
            end else if (tick && edge_q < EDGE_LAST) begin
                sclk_q <= ~sclk_q;
            end
        end
    end

    // Transmit shifter; inverted phase puts the first bit out at the command write.
    // [RL18] early first bit
    // [RL19] transmit order
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            txsh_q <= REG_RESET;
            sdo_q  <= 1'b0;
        end else if (i_ce) begin
            if (cmd_wr) begin
                if (inv_phase) begin
                    sdo_q  <= msb_first ? txreg_q[7] : txreg_q[0];
                    txsh_q <= msb_first ? {txreg_q[6:0], 1'b0} : {1'b0, txreg_q[7:1]};
                end else begin
                    txsh_q <= txreg_q;
                end
            end else if (drive_ev) begin
                sdo_q  <= next_bit;
                txsh_q <= msb_first ? {txsh_q[6:0], 1'b0} : {1'b0, txsh_q[7:1]};
            end
        end
    end

    // Receive shifter and receive register.
    // [RL19] receive order
    // [RL21] receive byte by busy clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rxsh_q  <= REG_RESET;
            rxreg_q <= REG_RESET;
        end else if (i_ce) begin
            if (sample_ev) begin
                rxsh_q <= msb_first ? {rxsh_q[6:0], i_sdi} : {i_sdi, rxsh_q[7:1]};
            end
            if (finish && cmd_q[CMD_RECEIVE]) begin
                rxreg_q <= rxsh_q;
            end
        end
    end

    // [RL21] release data out
    assign o_sdo_oe = busy_q && cmd_q[CMD_TRANSMIT];
    assign o_sdo    = sdo_q;
    assign o_sclk   = sclk_q;

endmodule

`default_nettype wire

// ==== serial_byte_master_port_assertions.sv ====
// Pin-level checks for the serial byte master port.
// Assumes control and command are written only while idle.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module serial_byte_master_port_assertions (
    input wire logic        i_clk_sys, // Clock.
    input wire logic        i_rst,     // Reset.
    input wire logic        i_ce,      // Clock enable.
    input wire logic [11:0] i_addr,    // Offset.
    input wire logic        i_wr,      // Write.
    input wire logic        i_rd,      // Read.
    input wire logic [7:0]  i_wdata,   // Write data.
    input wire logic [7:0]  o_rdata,   // Read data.
    input wire logic        o_irq,     // Interrupt.
    input wire logic        o_sclk,    // Serial clock.
    input wire logic        o_sdo,     // Serial data.
    input wire logic        o_sdo_oe   // Data enable.
);
    import serial_byte_master_pkg::*;
    logic [7:0] ctl_q, cmd_q;
    logic       sclk_q, seen_q, chg, wc, wm, w1c;
    int         cnt_q, edge_q, half;
    // Write decodes and serial clock change.
    assign wc   = i_ce && i_wr && i_addr == OFS_CONTROL;
    assign wm   = i_ce && i_wr && i_addr == OFS_COMMAND;
    assign w1c  = i_ce && i_wr && i_addr == OFS_STATUS && i_wdata[STA_DONE];
    assign chg  = o_sclk != sclk_q;
    assign half = HALF_BASE_CYCLES << ctl_q[CTL_RATE_LSB +: RATE_W];
    // Mirror settings; a write restarts edge counting so idle-level flips are not timed.
    // The mirrors freeze with the clock enable, as the design's timer does.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctl_q  <= REG_RESET;
            cmd_q  <= REG_RESET;
            sclk_q <= SCLK_RESET;
            seen_q <= 1'b0;
            cnt_q  <= 0;
            edge_q <= 0;
        end else if (i_ce) begin
            if (wc) ctl_q <= i_wdata;
            if (wm) cmd_q <= i_wdata;
            sclk_q <= o_sclk;
            seen_q <= (wc || wm) ? 1'b0 : (seen_q || chg);
            cnt_q  <= chg ? 0 : cnt_q + 1;
            edge_q <= (wc || wm) ? 0 : edge_q + int'(chg);
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_reset_outputs: assert property (
        $fell(i_rst) |-> o_sclk && !o_sdo_oe && !o_irq && o_rdata == REG_RESET)
        else $error("outputs not at reset values");
    a_half_period: assert property (
        chg && seen_q |-> cnt_q == half - 1)
        else $error("serial half period wrong");
    a_finish_time: assert property (
        $fell(o_sdo_oe) |-> (ctl_q[CTL_PHASE_INVERT] ? (chg && edge_q == 15)
                                                     : (edge_q == 16 && cnt_q == half - 1)))
        else $error("byte finished at wrong time");
    a_drive_edges: assert property (
        !ctl_q[CTL_PHASE_INVERT] && o_sdo_oe && $past(o_sdo_oe) && $changed(o_sdo)
        |-> chg && edge_q % 2 == 0)
        else $error("data changed off an odd edge");
    a_busy_read: assert property (
        wm ##2 (i_rd && i_addr == OFS_STATUS) |=> o_rdata[STA_BUSY])
        else $error("busy not set after command");
    a_idle_level: assert property (
        wc |-> ##2 o_sclk != ctl_q[CTL_CLOCK_IDLE_LOW])
        else $error("serial clock idle level wrong");
    a_irq_enable: assert property (
        o_irq |-> ctl_q[CTL_DONE_IRQ_ENABLE])
        else $error("interrupt while disabled");
    a_irq_clear: assert property (
        o_irq && w1c |=> !o_irq)
        else $error("done not cleared by one");
    a_irq_hold: assert property (
        o_irq && !wc && !w1c |=> o_irq)
        else $error("done dropped without clear");
    a_oe_transmit: assert property (
        o_sdo_oe |-> cmd_q[CMD_TRANSMIT])
        else $error("data driven without transmit");
    c_finish: cover property ($fell(o_sdo_oe));
    c_irq: cover property ($rose(o_irq));
    c_full_byte: cover property (edge_q == 16);
endmodule
bind serial_byte_master_port serial_byte_master_port_assertions u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_sclk(o_sclk), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe));
`default_nettype wire

// ==== serial_peripheral_model.sv ====
// Behavioural serial peripheral that shifts one byte each way.
// Assumes its select rises before a command and falls after it.
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_model (
    input  wire logic       i_sel,       // Select from a general pin.
    input  wire logic       i_sclk,      // Serial clock.
    input  wire logic       i_sdo,       // Line from the master.
    input  wire logic       i_phase_inv, // Phase setting.
    input  wire logic       i_msb,       // Bit order.
    input  wire logic [7:0] i_tx,        // Byte to send.
    output logic            o_sdi,       // Line to the master.
    output logic      [7:0] o_rx         // Byte received.
);
    int edges;
    int nd;
    int ns;
    initial o_sdi = 1'b0;
    task automatic put_bit();
        if (nd < 8) begin
            o_sdi = i_tx[i_msb ? 7 - nd : nd];
            nd++;
        end
    endtask
    // Select starts frame; inverted phase needs the first bit early.
    always @(posedge i_sel) begin
        edges = 0;
        nd = 0;
        ns = 0;
        if (i_phase_inv) put_bit();
    end
    // Drive on the master's drive edges, sample on the others.
    always @(i_sclk) begin
        if (i_sel) begin
            edges++;
            if ((edges % 2 == 1) != i_phase_inv) put_bit();
            else if (ns < 8) begin
                o_rx[i_msb ? 7 - ns : ns] = i_sdo;
                ns++;
            end
        end
    end
    // A released line must not keep its last bit, or a stale sample could pass.
    always @(negedge i_sel) o_sdi = ~o_sdi;
endmodule
`default_nettype wire

// ==== serial_byte_master_port_tb_top.sv ====
// Self-checking bench for the serial byte master port.
// Assumes the checker file is compiled too so that its bind attaches.
`timescale 1ns/1ps
`default_nettype none
module serial_byte_master_port_tb_top;
    import serial_byte_master_pkg::*;
    logic        clk_sys, rst, ce, wr, rd, irq, sclk, sdo, sdo_oe, sdi;
    logic        sdo_line, sel, ph, msb;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, stx, srx;
    int          miscompares = 0;
    int          total_checks = 0;
    // Clock at 200 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Released data line is pulled high.
    assign sdo_line = sdo_oe ? sdo : 1'b1;
    serial_byte_master_port uut (
        .i_clk_sys(clk_sys), .i_rst(rst), .i_ce(ce), .i_addr(addr), .i_wr(wr),
        .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_irq(irq), .o_sclk(sclk),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sdi(sdi));
    serial_peripheral_model u_peer (
        .i_sel(sel), .i_sclk(sclk), .i_sdo(sdo_line), .i_phase_inv(ph),
        .i_msb(msb), .i_tx(stx), .o_sdi(sdi), .o_rx(srx));
    ////////////////////////////////////////
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys);
        wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        @(negedge clk_sys);
        rd = 1'b0;
        d = rdata;
        @(negedge clk_sys);
    endtask
    task automatic xfer(input logic [7:0] c, cmd, t, s);
        logic [7:0] d;
        ph = c[CTL_PHASE_INVERT];
        msb = c[CTL_MSB_FIRST];
        stx = s;
        wr_reg(OFS_STATUS, 8'h02);
        wr_reg(OFS_CONTROL, c);
        wr_reg(OFS_TRANSMIT, t);
        sel = 1'b1;
        wr_reg(OFS_COMMAND, cmd);
        rd_reg(OFS_STATUS, d);
        check("busy", 8'h01, d);
        for (int i = 0; i < 500 && d[STA_BUSY] !== 1'b0; i++) rd_reg(OFS_STATUS, d);
        check("status", 8'h02, d);
        sel = 1'b0;
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        for (int a = 0; a < 6; a++) begin
            rd_reg(OFS_CONTROL + 12'(a), d);
            check("register", 8'h00, d);
        end
        check("idle pins", 8'h01, {6'h00, sdo_oe, sclk});
        $display("t_reset done");
    endtask
    task automatic t_high_idle();
        logic [7:0] d;
        xfer(8'h08, 8'h03, 8'ha5, 8'h3c);
        rd_reg(OFS_RECEIVE, d);
        check("receive", 8'h3c, d);
        check("peer byte", 8'ha5, srx);
        check("irq sclk", 8'h01, {6'h00, irq, sclk});
        $display("t_high_idle done");
    endtask
    task automatic t_three_wire();
        logic [7:0] d;
        xfer(8'h0f, 8'h03, 8'hc3, 8'h96);
        rd_reg(OFS_RECEIVE, d);
        check("receive", 8'h96, d);
        check("peer byte", 8'hc3, srx);
        check("irq sclk", 8'h02, {6'h00, irq, sclk});
        wr_reg(OFS_STATUS, 8'h00);
        check("irq kept", 8'h01, {7'h00, irq});
        wr_reg(OFS_STATUS, 8'h02);
        rd_reg(OFS_STATUS, d);
        check("cleared", 8'h00, {d[6:0], irq});
        $display("t_three_wire done");
    endtask
    task automatic t_lsb_transmit();
        logic [7:0] d;
        xfer(8'h10, 8'h01, 8'h2d, 8'hf0);
        check("peer byte", 8'h2d, srx);
        rd_reg(OFS_RECEIVE, d);
        check("receive kept", 8'h96, d);
        $display("t_lsb_transmit done");
    endtask
    task automatic t_nibble_receive();
        logic [7:0] d;
        xfer(8'h08, 8'h03, 8'hb0, 8'h69);
        rd_reg(OFS_RECEIVE, d);
        check("nibble", 8'h09, d & 8'h0f);
        xfer(8'h08, 8'h02, 8'h00, 8'h5a);
        rd_reg(OFS_RECEIVE, d);
        check("receive", 8'h5a, d);
        $display("t_nibble_receive done");
    endtask
    // Counts serial clock changes seen at the falling edges of a span.
    task automatic count_sclk(input int cycles, output int n);
        logic s;
        s = sclk;
        n = 0;
        repeat (cycles) begin
            @(negedge clk_sys);
            if (sclk !== s) n++;
            s = sclk;
        end
    endtask
    // A clocks-only byte is frozen by the enable, resumes, then a reset cuts it short.
    task automatic t_freeze_reset();
        logic [7:0] d;
        int         n;
        wr_reg(OFS_CONTROL, 8'h08);
        wr_reg(OFS_COMMAND, 8'h00);
        repeat (30) @(negedge clk_sys);
        ce = 1'b0;
        count_sclk(40, n);
        check("frozen sclk", 8'h00, 8'(n));
        ce = 1'b1;
        count_sclk(40, n);
        check("resumed sclk", 8'h03, 8'(n));
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        rd_reg(OFS_STATUS, d);
        check("reset status", 8'h00, d);
        count_sclk(60, n);
        check("idle pins", 8'h01, {6'h00, sdo_oe, sclk});
        check("idle edges", 8'h00, 8'(n));
        $display("t_freeze_reset done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset for two cycles, then run the scenarios.
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        {addr, wr, rd, wdata, sel, ph, msb, stx} = '0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_high_idle();
        t_three_wire();
        t_lsb_transmit();
        t_nibble_receive();
        t_freeze_reset();
        report_and_stop();
    end
    // The scenarios need under two thousand cycles; far beyond that is a hang.
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
